// ===== hw/save_state_component_tracker.sv
// in-use and modified tracking, save skip decision and owned registers
`timescale 1ns/10ps
`default_nettype none
module save_state_component_tracker (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // register bus
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [7:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  // core state summary
  input wire logic mode64_i,
  input wire logic [15:0] fp_control_word_i,
  input wire logic [15:0] fp_status_word_i,
  input wire logic [15:0] fp_tag_word_i,
  input wire logic fp_rest_zero_i,
  input wire logic [15:0] vec_zero_i,
  input wire logic [15:0] vec_upper_zero_i,
  input wire logic [15:0] wide_half_zero_i,
  input wire logic [15:0] upper_wide_zero_i,
  input wire logic [4:0] misc_zero_i,
  input wire logic [31:0] vector_control_status_i,
  input wire logic [16:0] comp_write_i,
  // current context
  input wire logic [1:0] privilege_level_i,
  input wire logic guest_mode_i,
  input wire logic [63:0] area_addr_i,
  input wire logic [63:0] compaction_vector_i,
  // restore and save requests
  input wire logic restore_i,
  input wire logic [16:0] restore_mask_i,
  input wire logic save_i,
  input wire logic [1:0] save_kind_i,
  input wire logic [16:0] save_mask_i,
  // save-area slot access
  input wire logic slot_rd_i,
  input wire logic slot_wr_i,
  input wire logic [4:0] slot_comp_i,
  input wire logic [1:0] slot_qword_i,
  input wire logic [63:0] slot_wdata_i,
  // results
  output logic [16:0] in_use_bitmap_o,
  output logic [16:0] modified_bitmap_o,
  output logic save_done_o,
  output logic [16:0] save_write_mask_o,
  output logic slot_rvalid_o,
  output logic slot_hit_o,
  output logic [63:0] slot_rdata_o
);
  typedef struct packed {
    logic aw_rdy;
    logic w_rdy;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic b_valid;
    logic [1:0] b_resp;
    logic ar_rdy;
    logic r_valid;
    logic [31:0] r_data;
    logic [1:0] r_resp;
    logic [2:0] ctrl;
    logic [31:0] uen;
    logic [31:0] sen;
    logic [16:0] in_use;
    logic [16:0] modified;
    logic [6:0][63:0] msr;
    logic tup_valid;
    logic [1:0] tup_priv;
    logic tup_guest;
    logic [63:0] tup_addr;
    logic [63:0] tup_cv;
    logic save_done;
    logic [16:0] save_wmask;
    logic slot_rvalid;
    logic slot_hit;
    logic [63:0] slot_rdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic [16:0] init_vec;
  logic slot_map_hit;
  logic [2:0] slot_idx;
  logic [31:0] xread_val;
  logic [16:0] perm;
  logic [16:0] save_rfbm;
  logic tuple_match;
  logic slot_ok;

  init_detect u_init (
    .mode64_i(mode64_i),
    .fp_control_word_i(fp_control_word_i),
    .fp_status_word_i(fp_status_word_i),
    .fp_tag_word_i(fp_tag_word_i),
    .fp_rest_zero_i(fp_rest_zero_i),
    .vec_zero_i(vec_zero_i),
    .vec_upper_zero_i(vec_upper_zero_i),
    .wide_half_zero_i(wide_half_zero_i),
    .upper_wide_zero_i(upper_wide_zero_i),
    .misc_zero_i(misc_zero_i),
    .msr_i(st_r.msr),
    .init_o(init_vec)
  );

  save_area_layout u_layout (
    .comp_i(slot_comp_i),
    .qword_i(slot_qword_i),
    .hit_o(slot_map_hit),
    .idx_o(slot_idx)
  );

  // component owning a model register slot
  function automatic logic [16:0] msr_comp(input logic [2:0] idx);
    logic [16:0] b;
    b = '0;
    if (idx < 3'h2) begin
      b[save_tracker_pkg::C_UFG] = 1'b1;
    end else if (idx < 3'h5) begin
      b[save_tracker_pkg::C_SFG] = 1'b1;
    end else if (idx == save_tracker_pkg::M_DUTY) begin
      b[save_tracker_pkg::C_DUTY] = 1'b1;
    end else begin
      b[save_tracker_pkg::C_PERF] = 1'b1;
    end
    return b;
  endfunction

  // word at a bus address, hit flag on top
  function automatic logic [32:0] reg_word(input logic [7:0] a);
    logic [7:0] off;
    logic [32:0] r;
    off = a - save_tracker_pkg::A_MSR_BASE;
    r = '0;
    if (a == save_tracker_pkg::A_CTRL) begin
      r = {1'b1, 29'h0, st_r.ctrl};
    end else if (a == save_tracker_pkg::A_UEN) begin
      r = {1'b1, st_r.uen};
    end else if (a == save_tracker_pkg::A_SEN) begin
      r = {1'b1, st_r.sen};
    end else if (a == save_tracker_pkg::A_INUSE) begin
      r = {1'b1, 15'h0, st_r.in_use};
    end else if (a == save_tracker_pkg::A_MOD) begin
      r = {1'b1, 15'h0, st_r.modified};
    end else if (a == save_tracker_pkg::A_XREAD) begin
      r = {1'b1, xread_val};
    end else if (a == save_tracker_pkg::A_TUPLE) begin
      r = {1'b1, 31'h0, st_r.tup_valid};
    end else if (a >= save_tracker_pkg::A_MSR_BASE &&
                 a < save_tracker_pkg::A_MSR_END && a[1:0] == 2'h0) begin
      r = {1'b1, off[2] ? st_r.msr[off[5:3]][63:32]
                        : st_r.msr[off[5:3]][31:0]};
    end
    return r;
  endfunction

  // permissions, selector-1 read value and tuple compare
  always_comb begin
    // R3 R5 R6 save enable and per-component enables
    perm = st_r.ctrl[save_tracker_pkg::CTRL_OSEN] ?
      ((st_r.uen[16:0] & ~save_tracker_pkg::SUP_MASK) |
       (st_r.sen[16:0] & save_tracker_pkg::SUP_MASK)) : 17'h0;
    // R13 enables AND in-use, bit 1 forced by vcs
    xread_val = st_r.uen & {15'h0, st_r.in_use};
    if (st_r.uen[1] && vector_control_status_i != save_tracker_pkg::VCS_RESET)
    begin
      xread_val[1] = 1'b1;
    end
    save_rfbm = save_mask_i & perm;
    if (save_kind_i != save_tracker_pkg::SAVE_SUPER) begin
      save_rfbm = save_rfbm & ~save_tracker_pkg::SUP_MASK;
    end
    // R14 all four parts must match
    tuple_match = st_r.tup_valid && st_r.tup_priv == privilege_level_i &&
      st_r.tup_guest == guest_mode_i && st_r.tup_addr == area_addr_i &&
      st_r.tup_cv == compaction_vector_i;
    slot_ok = slot_map_hit && perm[slot_comp_i];
  end

  // next state of the whole block
  always_comb begin
    logic [32:0] hw;
    logic [31:0] bmask;
    logic [31:0] merged;
    logic [7:0] off;
    logic [16:0] set_bits;
    logic [16:0] skip;
    hw = '0;
    bmask = '0;
    merged = '0;
    off = '0;
    set_bits = comp_write_i;
    skip = '0;
    st_nxt = st_r;
    st_nxt.save_done = 1'b0;
    st_nxt.slot_rvalid = 1'b0;
    // bus address and data capture, either order
    if (s_axi_awvalid_i && st_r.aw_rdy) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && st_r.w_rdy) begin
      st_nxt.w_have = 1'b1;
      st_nxt.w_data = s_axi_wdata_i;
      st_nxt.w_strb = s_axi_wstrb_i;
    end
    if (st_r.b_valid && s_axi_bready_i) begin
      st_nxt.b_valid = 1'b0;
    end
    // R4 register write, independent of save enables
    if (st_r.aw_have && st_r.w_have && !st_r.b_valid) begin
      hw = reg_word(st_r.aw_addr);
      for (int i = 0; i < 4; i++) begin
        bmask[i*8 +: 8] = {8{st_r.w_strb[i]}};
      end
      merged = (hw[31:0] & ~bmask) | (st_r.w_data & bmask);
      off = st_r.aw_addr - save_tracker_pkg::A_MSR_BASE;
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have = 1'b0;
      st_nxt.b_valid = 1'b1;
      st_nxt.b_resp = hw[32] ? save_tracker_pkg::RESP_OKAY
                             : save_tracker_pkg::RESP_SLVERR;
      if (st_r.aw_addr == save_tracker_pkg::A_CTRL) begin
        st_nxt.ctrl = merged[2:0];
      end else if (st_r.aw_addr == save_tracker_pkg::A_UEN) begin
        st_nxt.uen = merged;
      end else if (st_r.aw_addr == save_tracker_pkg::A_SEN) begin
        st_nxt.sen = merged;
      end else if (hw[32] && st_r.aw_addr >= save_tracker_pkg::A_MSR_BASE)
      begin
        if (off[2]) begin
          st_nxt.msr[off[5:3]][63:32] = merged;
        end else begin
          st_nxt.msr[off[5:3]][31:0] = merged;
        end
        set_bits = set_bits | msr_comp(off[5:3]);
      end
    end
    // bus read
    if (st_r.r_valid && s_axi_rready_i) begin
      st_nxt.r_valid = 1'b0;
    end
    if (s_axi_arvalid_i && st_r.ar_rdy) begin
      hw = reg_word(s_axi_araddr_i);
      st_nxt.r_valid = 1'b1;
      st_nxt.r_data = hw[31:0];
      st_nxt.r_resp = hw[32] ? save_tracker_pkg::RESP_OKAY
                             : save_tracker_pkg::RESP_SLVERR;
    end
    // R1 R2 R3 slot access only when permitted
    if (slot_wr_i && slot_ok) begin
      st_nxt.msr[slot_idx] = slot_wdata_i;
      set_bits = set_bits | msr_comp(slot_idx);
    end
    if (slot_rd_i) begin
      st_nxt.slot_rvalid = 1'b1;
      st_nxt.slot_hit = slot_ok;
      st_nxt.slot_rdata = slot_ok ? st_r.msr[slot_idx] : 64'h0;
    end
    // R10 clear only from a known initial value, a write re-sets
    if (st_r.ctrl[save_tracker_pkg::CTRL_TRK_INIT]) begin
      st_nxt.in_use = ~init_vec | set_bits;
    end else begin
      // R12 no init tracking
      st_nxt.in_use = '1;
    end
    // R11 restore clears restored bits, a write in the same cycle wins
    if (st_r.ctrl[save_tracker_pkg::CTRL_TRK_MOD]) begin
      st_nxt.modified = (restore_i ? ~restore_mask_i : st_r.modified) |
        set_bits;
    end else begin
      // R12 no modified tracking
      st_nxt.modified = '1;
    end
    // R14 record the restore tuple
    if (restore_i) begin
      st_nxt.tup_valid = 1'b1;
      st_nxt.tup_priv = privilege_level_i;
      st_nxt.tup_guest = guest_mode_i;
      st_nxt.tup_addr = area_addr_i;
      st_nxt.tup_cv = compaction_vector_i;
    end
    // R7 R8 R9 save skip decision per kind
    if (save_i) begin
      if (save_kind_i != save_tracker_pkg::SAVE_PLAIN) begin
        skip = ~st_r.in_use;
      end
      if ((save_kind_i == save_tracker_pkg::SAVE_OPT ||
           save_kind_i == save_tracker_pkg::SAVE_SUPER) && tuple_match) begin
        skip = skip | ~st_r.modified;
      end
      st_nxt.save_done = 1'b1;
      st_nxt.save_wmask = save_rfbm & ~skip;
    end
    // bus readiness follows held state
    st_nxt.aw_rdy = !st_nxt.aw_have && !st_nxt.b_valid;
    st_nxt.w_rdy = !st_nxt.w_have && !st_nxt.b_valid;
    st_nxt.ar_rdy = !st_nxt.r_valid;
  end

  // state register
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r <= '0;
      st_r.ctrl <= save_tracker_pkg::CTRL_RESET;
      // R23 pessimistic tracking after reset
      st_r.in_use <= '1;
      st_r.modified <= '1;
      st_r.msr[save_tracker_pkg::M_DUTY] <= save_tracker_pkg::DUTY_INIT;
      st_r.msr[save_tracker_pkg::M_PERF] <= save_tracker_pkg::PERF_INIT;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from state
  assign s_axi_awready_o = st_r.aw_rdy;
  assign s_axi_wready_o = st_r.w_rdy;
  assign s_axi_bvalid_o = st_r.b_valid;
  assign s_axi_bresp_o = st_r.b_resp;
  assign s_axi_arready_o = st_r.ar_rdy;
  assign s_axi_rvalid_o = st_r.r_valid;
  assign s_axi_rdata_o = st_r.r_data;
  assign s_axi_rresp_o = st_r.r_resp;
  assign in_use_bitmap_o = st_r.in_use;
  assign modified_bitmap_o = st_r.modified;
  assign save_done_o = st_r.save_done;
  assign save_write_mask_o = st_r.save_wmask;
  assign slot_rvalid_o = st_r.slot_rvalid;
  assign slot_hit_o = st_r.slot_hit;
  assign slot_rdata_o = st_r.slot_rdata;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_plain_full: assert property ( // R9
    save_i && save_kind_i == save_tracker_pkg::SAVE_PLAIN
    |=> save_done_o && save_write_mask_o == $past(save_rfbm))
    else $error("plain save skipped a component");
  a_compact_init: assert property ( // R9
    save_i && save_kind_i == save_tracker_pkg::SAVE_COMPACT
    |=> save_write_mask_o == ($past(save_rfbm) & $past(st_r.in_use)))
    else $error("compacting save mask wrong");
  a_init_skip: assert property ( // R7
    save_i && save_kind_i != save_tracker_pkg::SAVE_PLAIN
    |=> (save_write_mask_o & ~$past(st_r.in_use)) == 17'h0)
    else $error("save wrote a component not in use");
  a_ufg_gate: assert property ( // R3
    save_done_o && save_write_mask_o[save_tracker_pkg::C_UFG]
    |-> $past(st_r.ctrl[save_tracker_pkg::CTRL_OSEN] && st_r.sen[11]))
    else $error("user flow-guard saved without enable");
  a_perf_gate: assert property ( // R6
    slot_rd_i && slot_comp_i == 5'h10 && !perm[save_tracker_pkg::C_PERF]
    |=> slot_rvalid_o && !slot_hit_o && slot_rdata_o == 64'h0)
    else $error("perf-state slot read while disabled");
  a_duty_clear: assert property ( // R21
    !st_r.in_use[save_tracker_pkg::C_DUTY]
    |-> st_r.msr[save_tracker_pkg::M_DUTY] == save_tracker_pkg::DUTY_INIT)
    else $error("duty-cycle in-use cleared while not initial");
  a_perf_clear: assert property ( // R22
    !st_r.in_use[save_tracker_pkg::C_PERF]
    |-> st_r.msr[save_tracker_pkg::M_PERF] == save_tracker_pkg::PERF_INIT)
    else $error("perf-state in-use cleared while not initial");
  a_no_track: assert property ( // R12
    !st_r.ctrl[save_tracker_pkg::CTRL_TRK_MOD] |=> &modified_bitmap_o)
    else $error("modified bit low without tracking");
  a_xread_bit1: assert property ( // R13
    s_axi_arvalid_i && s_axi_arready_o &&
    s_axi_araddr_i == save_tracker_pkg::A_XREAD && st_r.uen[1] &&
    vector_control_status_i != save_tracker_pkg::VCS_RESET
    |=> s_axi_rvalid_o && s_axi_rdata_o[1])
    else $error("selector-1 read bit 1 not forced");
  a_tuple_record: assert property ( // R14
    restore_i |=> st_r.tup_valid && st_r.tup_addr == $past(area_addr_i))
    else $error("restore tuple not recorded");
  c_opt_match: cover property (save_i && tuple_match &&
    save_kind_i == save_tracker_pkg::SAVE_OPT);
  c_bus_write: cover property (s_axi_bvalid_o && s_axi_bready_i);
  c_slot_hit: cover property (slot_rvalid_o && slot_hit_o);
endmodule // save_state_component_tracker
`default_nettype wire

// ===== hw/save_tracker_pkg.sv
// constants for the save state component tracker
// What this block does
// R1 - user flow-guard area: control in bytes 7:0, user shadow pointer 15:8
// R2 - supervisor flow-guard area: ring i shadow pointer at bytes 8i+7:8i
// R3 - flow-guard components need save enable plus supervisor bit 11 or 12
// R4 - model registers stay bus reachable whatever the save enables say
// R5 - duty-cycle control is component 13, 8 bytes at 0, gated by bit 13
// R6 - perf-state request is component 16, 8 bytes at 0, gated by bit 16
// R7 - optimized, compacting, supervisor saves may skip components not in use
// R8 - optimized, supervisor saves skip unmodified parts only on same area
// R9 - plain save never skips; compacting save never uses modified skip
// R10 - in-use bit clears only when component is known initial
// R11 - modified bit clears only when known unchanged since last restore
// R12 - without tracking every in-use and modified bit reads one
// R13 - selector-1 read gives enables AND in-use, bit 1 forced when vcs is not 1F80
// R14 - restore records privilege, guest flag, area address, compaction vector
// R15 - applications should avoid the optimized save
// R16 - fp stack initial: cw 037F, sw 0000, tw FFFF, rest zero
// R17 - in-use bit 1 covers vector registers only, 16 or 8 by mode
// R18 - upper halves initial when zero, 16 or 8 registers by mode
// R19 - bound, mask, trace, key rights and flow-guard initial when zero
// R20 - upper wide vectors always initial outside 64-bit mode
// R21 - duty-cycle component initial only when its register equals 1
// R22 - perf-state component initial only when request is 8000FF01
// R23 - reset sets all in-use and modified bits, drops restore record
package save_tracker_pkg;
  localparam int NCOMP = 17;
  localparam int NMSR = 7;
  // component indices
  localparam int C_FP = 0;
  localparam int C_VEC = 1;
  localparam int C_VEC_UP = 2;
  localparam int C_BND_REGS = 3;
  localparam int C_BND_CFG = 4;
  localparam int C_MASK = 5;
  localparam int C_WIDE_HALF = 6;
  localparam int C_UP_WIDE = 7;
  localparam int C_TRACE = 8;
  localparam int C_PKEY = 9;
  localparam int C_UFG = 11;
  localparam int C_SFG = 12;
  localparam int C_DUTY = 13;
  localparam int C_PERF = 16;
  localparam logic [16:0] SUP_MASK = 17'h13800;
  // model register slots
  localparam logic [2:0] M_UCTRL = 3'h0;
  localparam logic [2:0] M_UPTR = 3'h1;
  localparam logic [2:0] M_RING0 = 3'h2;
  localparam logic [2:0] M_DUTY = 3'h5;
  localparam logic [2:0] M_PERF = 3'h6;
  // initial values
  localparam logic [15:0] FP_CW_INIT = 16'h037F;
  localparam logic [15:0] FP_SW_INIT = 16'h0000;
  localparam logic [15:0] FP_TW_INIT = 16'hFFFF;
  localparam logic [63:0] DUTY_INIT = 64'h0000_0000_0000_0001;
  localparam logic [63:0] PERF_INIT = 64'h0000_0000_8000_FF01;
  localparam logic [31:0] VCS_RESET = 32'h0000_1F80;
  localparam logic [15:0] HIGH8_MASK = 16'hFF00;
  // register map
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_UEN = 8'h04;
  localparam logic [7:0] A_SEN = 8'h08;
  localparam logic [7:0] A_INUSE = 8'h0C;
  localparam logic [7:0] A_MOD = 8'h10;
  localparam logic [7:0] A_XREAD = 8'h14;
  localparam logic [7:0] A_TUPLE = 8'h18;
  localparam logic [7:0] A_MSR_BASE = 8'h20;
  localparam logic [7:0] A_MSR_END = 8'h58;
  localparam int CTRL_OSEN = 0;
  localparam int CTRL_TRK_INIT = 1;
  localparam int CTRL_TRK_MOD = 2;
  localparam logic [2:0] CTRL_RESET = 3'h6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    SAVE_PLAIN = 2'h0,
    SAVE_OPT = 2'h1,
    SAVE_COMPACT = 2'h2,
    SAVE_SUPER = 2'h3
  } save_kind_t;
endpackage

// ===== hw/init_detect.sv
// initial-configuration detector for every tracked component
`timescale 1ns/10ps
`default_nettype none
module init_detect (
  // mode
  input wire logic mode64_i,
  // fp stack
  input wire logic [15:0] fp_control_word_i,
  input wire logic [15:0] fp_status_word_i,
  input wire logic [15:0] fp_tag_word_i,
  input wire logic fp_rest_zero_i,
  // per-register zero flags
  input wire logic [15:0] vec_zero_i,
  input wire logic [15:0] vec_upper_zero_i,
  input wire logic [15:0] wide_half_zero_i,
  input wire logic [15:0] upper_wide_zero_i,
  input wire logic [4:0] misc_zero_i,
  // owned model registers
  input wire logic [6:0][63:0] msr_i,
  // result
  output logic [16:0] init_o
);
  logic [15:0] ignore;
  always_comb begin
    // outside 64-bit mode the high eight registers do not count
    ignore = mode64_i ? 16'h0000 : save_tracker_pkg::HIGH8_MASK;
    init_o = '0;
    // R16 fp stack values
    init_o[save_tracker_pkg::C_FP] =
      (fp_control_word_i == save_tracker_pkg::FP_CW_INIT) &&
      (fp_status_word_i == save_tracker_pkg::FP_SW_INIT) &&
      (fp_tag_word_i == save_tracker_pkg::FP_TW_INIT) && fp_rest_zero_i;
    // R17 vector registers only
    init_o[save_tracker_pkg::C_VEC] = &(vec_zero_i | ignore);
    // R18 upper halves by mode
    init_o[save_tracker_pkg::C_VEC_UP] = &(vec_upper_zero_i | ignore);
    init_o[save_tracker_pkg::C_WIDE_HALF] = &(wide_half_zero_i | ignore);
    // R20 upper wide set outside 64-bit mode
    init_o[save_tracker_pkg::C_UP_WIDE] = !mode64_i || &upper_wide_zero_i;
    // R19 all-zero components
    init_o[save_tracker_pkg::C_BND_REGS] = misc_zero_i[0];
    init_o[save_tracker_pkg::C_BND_CFG] = misc_zero_i[1];
    init_o[save_tracker_pkg::C_MASK] = misc_zero_i[2];
    init_o[save_tracker_pkg::C_TRACE] = misc_zero_i[3];
    init_o[save_tracker_pkg::C_PKEY] = misc_zero_i[4];
    init_o[save_tracker_pkg::C_UFG] = (msr_i[0] == '0) && (msr_i[1] == '0);
    init_o[save_tracker_pkg::C_SFG] =
      (msr_i[2] == '0) && (msr_i[3] == '0) && (msr_i[4] == '0);
    // R21 duty-cycle value
    init_o[save_tracker_pkg::C_DUTY] =
      (msr_i[5] == save_tracker_pkg::DUTY_INIT);
    // R22 perf-state value
    init_o[save_tracker_pkg::C_PERF] =
      (msr_i[6] == save_tracker_pkg::PERF_INIT);
  end
endmodule // init_detect
`default_nettype wire

// ===== hw/save_area_layout.sv
// maps a component and quadword to an owned model register slot
`timescale 1ns/10ps
`default_nettype none
module save_area_layout (
  // location in the save area
  input wire logic [4:0] comp_i,
  input wire logic [1:0] qword_i,
  // slot
  output logic hit_o,
  output logic [2:0] idx_o
);
  always_comb begin
    hit_o = 1'b0;
    idx_o = 3'h0;
    // R1 control first, user pointer second
    if (comp_i == 5'h0B && qword_i < 2'h2) begin
      hit_o = 1'b1;
      idx_o = save_tracker_pkg::M_UCTRL + {1'b0, qword_i};
    // R2 ring pointers in ring order
    end else if (comp_i == 5'h0C && qword_i < 2'h3) begin
      hit_o = 1'b1;
      idx_o = save_tracker_pkg::M_RING0 + {1'b0, qword_i};
    // R5 duty-cycle at offset 0
    end else if (comp_i == 5'h0D && qword_i == 2'h0) begin
      hit_o = 1'b1;
      idx_o = save_tracker_pkg::M_DUTY;
    // R6 perf-state at offset 0
    end else if (comp_i == 5'h10 && qword_i == 2'h0) begin
      hit_o = 1'b1;
      idx_o = save_tracker_pkg::M_PERF;
    end
  end
endmodule // save_area_layout
`default_nettype wire

// ===== verif/testbench.sv
// self-checking bench for the save state component tracker
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk_i, reset_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
  logic s_axi_arvalid_i, s_axi_rready_i, mode64_i, fp_rest_zero_i;
  logic restore_i, save_i, slot_rd_i, slot_wr_i, guest_mode_i;
  logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, vector_control_status_i, g;
  logic [3:0] s_axi_wstrb_i;
  logic [15:0] fp_control_word_i, fp_status_word_i, fp_tag_word_i;
  logic [15:0] vec_zero_i, vec_upper_zero_i, wide_half_zero_i;
  logic [15:0] upper_wide_zero_i;
  logic [4:0] misc_zero_i, slot_comp_i;
  logic [16:0] comp_write_i, restore_mask_i, save_mask_i;
  logic [1:0] privilege_level_i, save_kind_i, slot_qword_i, rs;
  logic [63:0] area_addr_i, compaction_vector_i, slot_wdata_i;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  logic s_axi_rvalid_o, save_done_o, slot_rvalid_o, slot_hit_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_rdata_o;
  logic [16:0] in_use_bitmap_o, modified_bitmap_o, save_write_mask_o;
  logic [63:0] slot_rdata_o;
  int num_errors, total_checks;
  save_state_component_tracker i_save_state_component_tracker (.*);
  // clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    do begin
      @(negedge clk_i);
      aw = s_axi_awready_o;
      w = s_axi_wready_o;
      b = s_axi_bvalid_o;
      rs = s_axi_bresp_o;
      @(posedge clk_i);
      if (aw) s_axi_awvalid_i <= 1'b0;
      if (w) s_axi_wvalid_i <= 1'b0;
    end while (b !== 1'b1);
  endtask
  // bus read, data and response taken with rvalid
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic ar, r;
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    do begin
      @(negedge clk_i);
      ar = s_axi_arready_o;
      r = s_axi_rvalid_o;
      d = s_axi_rdata_o;
      rs = s_axi_rresp_o;
      @(posedge clk_i);
      if (ar) s_axi_arvalid_i <= 1'b0;
    end while (r !== 1'b1);
  endtask
  // one save request, done flag packed into bit 31
  task automatic sv(input logic [1:0] k, input logic [16:0] m);
    save_i <= 1'b1;
    save_kind_i <= k;
    save_mask_i <= m;
    @(posedge clk_i);
    save_i <= 1'b0;
    @(negedge clk_i);
    g = {save_done_o, 14'h0, save_write_mask_o};
    @(posedge clk_i);
  endtask
  // reset values while held, release, then an unmapped place
  task automatic t_reset();
    chk({15'h0, in_use_bitmap_o}, 32'h1FFFF);
    chk({15'h0, modified_bitmap_o}, 32'h1FFFF);
    reset_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rd(8'h18, g);
    chk(g, 32'h0);
    rd(8'h50, g);
    chk(g, 32'h8000FF01);
    wr(8'h5C, 32'h1);
    chk({30'h0, rs}, 32'h2);
    rd(8'h5C, g);
    chk({30'h0, rs}, 32'h2);
  endtask
  // detectors, mode-dependent vector counts
  task automatic t_init();
    repeat (3) @(posedge clk_i);
    chk({15'h0, in_use_bitmap_o}, 32'hC400);
    fp_control_word_i <= 16'h0;
    repeat (3) @(posedge clk_i);
    chk({15'h0, in_use_bitmap_o}, 32'hC401);
    mode64_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({15'h0, in_use_bitmap_o}, 32'hC483);
    mode64_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  // selector-one read and save gating
  task automatic t_save();
    wr(8'h00, 32'h7);
    wr(8'h04, 32'h3);
    rd(8'h14, g);
    chk(g, 32'h1);
    vector_control_status_i <= 32'h0;
    rd(8'h14, g);
    chk(g, 32'h3);
    sv(2'h0, 17'h3);
    chk(g, 32'h80000003);
    sv(2'h2, 17'h3);
    chk(g, 32'h80000001);
    sv(2'h1, 17'h3);
    chk(g, 32'h80000001);
    wr(8'h48, 32'h0);
    rd(8'h48, g);
    chk(g, 32'h0);
    chk({31'h0, in_use_bitmap_o[13]}, 32'h1);
    sv(2'h3, 17'h02800);
    chk(g, 32'h80000000);
    wr(8'h08, 32'h2000);
    sv(2'h3, 17'h02800);
    chk(g, 32'h80002000);
  endtask
  // restore record and the modified skip per save kind
  task automatic t_track();
    restore_mask_i <= 17'h00001;
    restore_i <= 1'b1;
    @(posedge clk_i);
    restore_i <= 1'b0;
    @(posedge clk_i);
    chk({15'h0, modified_bitmap_o}, 32'h1FFFE);
    // optimized save issued only from the kernel side here
    sv(2'h1, 17'h3);
    chk(g, 32'h80000000);
    sv(2'h2, 17'h3);
    chk(g, 32'h80000001);
    area_addr_i <= 64'h40;
    sv(2'h1, 17'h3);
    chk(g, 32'h80000001);
    rd(8'h18, g);
    chk(g, 32'h1);
  endtask
  // slot write and read, permitted and refused
  task automatic t_slot();
    slot_comp_i <= 5'h0D;
    slot_wdata_i <= 64'h1;
    slot_wr_i <= 1'b1;
    @(posedge clk_i);
    slot_wr_i <= 1'b0;
    slot_rd_i <= 1'b1;
    @(posedge clk_i);
    slot_comp_i <= 5'h10;
    @(negedge clk_i);
    chk({slot_rvalid_o, slot_hit_o, slot_rdata_o[29:0]}, 32'hC0000001);
    chk({31'h0, in_use_bitmap_o[13]}, 32'h0);
    @(posedge clk_i);
    slot_rd_i <= 1'b0;
    @(negedge clk_i);
    chk({slot_rvalid_o, slot_hit_o, slot_rdata_o[29:0]}, 32'h80000000);
    @(posedge clk_i);
  endtask
  // verdict
  task automatic complete_run();
    $display("errors=%0d checks=%0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    complete_run();
  end
  // stimulus
  initial begin
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_arvalid_i, restore_i, save_i} = '0;
    {slot_rd_i, slot_wr_i, guest_mode_i, mode64_i, s_axi_awaddr_i} = '0;
    {s_axi_araddr_i, s_axi_wdata_i, comp_write_i, restore_mask_i} = '0;
    {save_mask_i, privilege_level_i, save_kind_i, slot_comp_i} = '0;
    {slot_qword_i, area_addr_i, compaction_vector_i, slot_wdata_i} = '0;
    {fp_status_word_i, upper_wide_zero_i} = '0;
    {s_axi_bready_i, s_axi_rready_i, reset_i, fp_rest_zero_i} = '1;
    {vec_upper_zero_i, wide_half_zero_i, misc_zero_i} = '1;
    s_axi_wstrb_i = 4'hF;
    vec_zero_i = 16'h00FF;
    fp_control_word_i = 16'h037F;
    fp_tag_word_i = 16'hFFFF;
    vector_control_status_i = 32'h00001F80;
    repeat (10) @(posedge clk_i);
    t_reset();
    t_init();
    t_save();
    t_track();
    t_slot();
    complete_run();
  end
endmodule // testbench
`default_nettype wire
